/* irap_params.svh */
// Constants for the indirect register access port
`ifndef IRAP_PARAMS_SVH
`define IRAP_PARAMS_SVH
`define IRAP_NUM_REGS       6
`define IRAP_SEL_RESET      16'h0000
`define IRAP_SEL_BYTEMODE   7
`define IRAP_SEL_IDX_HI     3
`define IRAP_SEL_IDX_LO     1
`define IRAP_SEL_UPPER      0
`define IRAP_SEL_WMASK      16'h008f
`define IRAP_REG_RESET      16'h0000
`endif

/* irap_pkg.sv */
// Types shared by the indirect register access port
package irap_pkg;
  // Decoded select port contents
  typedef struct packed {
    logic       byteMode;
    logic [2:0] regIndex;
    logic       upperHalf;
  } irap_sel_s;
  // One host bus access as seen by the register bank
  typedef struct packed {
    logic        wrEn;
    logic [2:0]  regIndex;
    logic [1:0]  laneEn;
    logic [15:0] wrData;
  } irap_acc_s;
  // Host handshake states, one-hot
  typedef enum logic [1:0] {
    IRAP_HS_IDLE = 2'b01,
    IRAP_HS_HOLD = 2'b10
  } irap_hs_e;
endpackage

/* irap_reg_bank.sv */
// Bank of six 16-bit control/status registers with byte lanes
`timescale 1ns/1ns
`include "irap_params.svh"
module irap_reg_bank
  import irap_pkg::*;
#(
  parameter int NUM_REGS = `IRAP_NUM_REGS
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Access from the port logic
  input  wire irap_acc_s     acc,
  output logic [15:0]        rdData,
  // Register contents for the rest of the device
  output logic [NUM_REGS*16-1:0] regFlat
);
  logic [15:0] regs_ff [NUM_REGS]; // Storage, one word per register

  // Write with byte lanes; indexes beyond the bank are dropped
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= `IRAP_REG_RESET;
    end else if (acc.wrEn && (int'(acc.regIndex) < NUM_REGS)) begin
      if (acc.laneEn[0]) regs_ff[acc.regIndex][7:0]  <= acc.wrData[7:0];
      if (acc.laneEn[1]) regs_ff[acc.regIndex][15:8] <= acc.wrData[15:8];
    end
  end

  // Read mux; unmapped indexes read as zero
  always_comb begin
    rdData = 16'h0000;
    if (int'(acc.regIndex) < NUM_REGS) rdData = regs_ff[acc.regIndex];
  end

  // Flatten for export
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) regFlat[i*16 +: 16] = regs_ff[i];
  end
endmodule

/* irap_host_port.sv */
// Host slave port: select port plus data window onto six registers
`timescale 1ns/1ns
`include "irap_params.svh"
module irap_host_port
  import irap_pkg::*;
#(
  parameter int NUM_REGS = `IRAP_NUM_REGS
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Host bus pins, sampled through two flops
  input  wire logic              hostSel,
  input  wire logic              hostRd,
  input  wire logic              hostWr,
  input  wire logic              portSelect,
  input  wire logic [15:0]       hostDataIn,
  // Host data return
  output logic [15:0]            hostDataOut,
  output logic                   hostDataOe_n,
  output logic                   hostAck,
  // Device side view
  output irap_sel_s              selState,
  output logic [NUM_REGS*16-1:0] regFlat
);
  // Timing seen from the pins: a strobe is decoded two edges after it
  // reaches the pins, the access is taken on the next edge and the
  // answer rises on that same edge. The host must therefore keep its
  // strobe up until it sees the answer, and leave a few idle cycles
  // between accesses so that the release is seen before a new strobe.
  //
  // Pin synchronisers; first stage feeds only second stage
  logic [19:0] pinMeta_ff;  // First stage, may settle late
  logic [19:0] pinSync_ff;  // Second stage, the only one decoded
  logic [15:0] dIn;         // Synced host write data
  logic        sSel;        // Synced chip select
  logic        sRd;         // Synced read strobe
  logic        sWr;         // Synced write strobe
  logic        sPort;       // Synced port pin, high picks select port
  logic        strobeOn;    // Synced select with either strobe up
  logic        start;       // Access taken in this cycle

  // Handshake, select port and read return
  irap_hs_e    hsState_ff;  // Handshake state
  irap_hs_e    nxt_hsState; // Next handshake state
  logic [15:0] selPort_ff;  // Select port contents
  logic [15:0] nxt_selPort; // Next select port contents
  logic [15:0] rdHold_ff;   // Data returned to host
  logic [15:0] nxt_rdHold;  // Next read return word
  logic        oe_ff;       // Host data drive, active high inside

  // Path to the register bank
  irap_acc_s   acc;         // Access steered to the bank
  logic [15:0] bankRd;      // Word read out of the bank

  // Strobe decode, shared by the access start and the handshake
  function automatic logic isStrobe(input logic sel,
                                    input logic rd,
                                    input logic wr);
    return sel && (rd || wr);
  endfunction

  // Byte lanes of a data window write; word mode writes both halves
  function automatic logic [1:0] laneMask(input logic byteMode,
                                          input logic upper);
    if (!byteMode) return 2'b11;
    return upper ? 2'b10 : 2'b01;
  endfunction

  // Chosen half of a register word, zero extended for the host
  function automatic logic [15:0] byteOf(input logic [15:0] value,
                                         input logic upper);
    return {8'h00, upper ? value[15:8] : value[7:0]};
  endfunction

  // Two-flop synchroniser on all bus pins. The data lines ride along
  // with the strobes: the host holds them steady for the whole access,
  // so they have long settled by the time the synced strobe is decoded.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pinMeta_ff <= 20'h00000;
      pinSync_ff <= 20'h00000;
    end else begin
      pinMeta_ff <= {hostSel, hostRd, hostWr, portSelect, hostDataIn};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // Split the synced pins back into their roles
  assign {sSel, sRd, sWr, sPort, dIn} = pinSync_ff;
  assign strobeOn = isStrobe(sSel, sRd, sWr);

  // An access is taken once per strobe assertion, and only from idle,
  // so a host that holds its strobe for many cycles is served once
  assign start = strobeOn && (hsState_ff == IRAP_HS_IDLE);

  // Handshake next state: answer once, then wait for the strobe to drop
  always_comb begin
    nxt_hsState = hsState_ff;
    case (hsState_ff)
      IRAP_HS_IDLE: begin
        // A new strobe is taken now and answered on the next edge
        if (strobeOn) nxt_hsState = IRAP_HS_HOLD;
      end
      IRAP_HS_HOLD: begin
        // Answer stands until the synced strobe goes away
        if (!strobeOn) nxt_hsState = IRAP_HS_IDLE;
      end
      default: begin
        // Not a legal one-hot code; fall back to idle
        nxt_hsState = IRAP_HS_IDLE;
      end
    endcase
  end

  // Handshake state register
  always_ff @(posedge sys_clk) begin
    if (!nrst) hsState_ff <= IRAP_HS_IDLE;
    else hsState_ff <= nxt_hsState;
  end

  // Select port next value. Only a write with the port pin high lands;
  // data window traffic leaves it alone however long the host keeps
  // using the same register. Reserved bits are masked so they read 0.
  always_comb begin
    nxt_selPort = selPort_ff;
    if (start && sWr && sPort) begin
      nxt_selPort = dIn & `IRAP_SEL_WMASK;
    end
  end

  // Select port register; bus reset clears index and both mode bits
  always_ff @(posedge sys_clk) begin
    if (!nrst) selPort_ff <= `IRAP_SEL_RESET;
    else selPort_ff <= nxt_selPort;
  end

  // Decoded view of the select port for the rest of the device
  assign selState = {selPort_ff[`IRAP_SEL_BYTEMODE],
                     selPort_ff[`IRAP_SEL_IDX_HI:`IRAP_SEL_IDX_LO],
                     selPort_ff[`IRAP_SEL_UPPER]};

  // Data window access steering. In byte mode the host moves one byte
  // on the low data lines; it is copied to both halves and the lane
  // mask picks which half of the register actually takes it.
  always_comb begin
    acc.wrEn     = start && sWr && !sPort;
    acc.regIndex = selState.regIndex;
    acc.laneEn   = laneMask(selState.byteMode, selState.upperHalf);
    if (selState.byteMode) begin
      // Byte transfers: one byte from the low lines
      acc.wrData = {dIn[7:0], dIn[7:0]};
    end else begin
      // Word transfers: all sixteen lines
      acc.wrData = dIn;
    end
  end

  // The six registers live in their own bank; writes to index 6 and 7
  // are dropped there and reads of them return zero
  irap_reg_bank #(.NUM_REGS(NUM_REGS)) uBank (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .acc     (acc),
    .rdData  (bankRd),
    .regFlat (regFlat)
  );

  // Read return next value, captured when a read is taken. The word is
  // held afterwards so the host may sample it late in its cycle.
  always_comb begin
    nxt_rdHold = rdHold_ff;
    if (start && sRd) begin
      if (sPort) begin
        // Select port reads back its stored value
        nxt_rdHold = selPort_ff;
      end else if (selState.byteMode) begin
        // Byte mode: chosen half, zero extended
        nxt_rdHold = byteOf(bankRd, selState.upperHalf);
      end else begin
        // Word mode: the whole register
        nxt_rdHold = bankRd;
      end
    end
  end

  // Read return register
  always_ff @(posedge sys_clk) begin
    if (!nrst) rdHold_ff <= 16'h0000;
    else rdHold_ff <= nxt_rdHold;
  end

  // Drive enable for the host data lines: on from a taken read until
  // the synced strobe drops. Turning it off a few cycles after the
  // host lets go costs some bus time but never fights the host.
  always_ff @(posedge sys_clk) begin
    if (!nrst) oe_ff <= 1'b0;
    else oe_ff <= (start && sRd) || (oe_ff && sSel && sRd);
  end

  // Outputs: data and enable from flops, answer decoded from state
  assign hostDataOut  = rdHold_ff;
  assign hostDataOe_n = !oe_ff;
  assign hostAck      = (hsState_ff == IRAP_HS_HOLD);
endmodule

/* irap_host_port_monitor.sv */
// Checker for the indirect register access port
`timescale 1ns/1ns
module irap_host_port_monitor
  import irap_pkg::*;
#(parameter int NUM_REGS = 6) (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  // Host pins
  input wire logic                   hostSel,
  input wire logic                   hostRd,
  input wire logic                   hostWr,
  input wire logic                   portSelect,
  input wire logic [15:0]            hostDataIn,
  input wire logic [15:0]            hostDataOut,
  input wire logic                   hostDataOe_n,
  input wire logic                   hostAck,
  // Device view
  input wire irap_sel_s              selState,
  input wire logic [NUM_REGS*16-1:0] regFlat
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Pins show no select write for as long as the sync path takes
  sequence quiet_sel;
    !(hostSel && hostWr && portSelect) [*4];
  endsequence
  chk_reset_clear: assert property (
    disable iff (1'b0) !nrst |=> selState == '0 && regFlat == '0)
    else $error("reset left state behind");
  chk_sel_holds: assert property (quiet_sel |-> $stable(selState))
    else $error("select port changed without a write");
  chk_ack_bound: assert property (
    $rose(hostSel && (hostRd || hostWr)) |-> ##[1:4] hostAck)
    else $error("access never answered");
  chk_idle_quiet: assert property (!hostSel [*5] |-> !hostAck)
    else $error("answer with no chip select");
  chk_oe_read: assert property (
    $rose(hostAck) |-> hostDataOe_n == !hostRd)
    else $error("data drive wrong for access kind");
  chk_sel_read: assert property (hostAck && hostRd && portSelect |->
    hostDataOut == {8'h00, selState.byteMode, 3'h0, selState.regIndex,
    selState.upperHalf}) else $error("select port read wrong");
  chk_word_read: assert property (hostAck && hostRd && !portSelect &&
    !selState.byteMode && selState.regIndex < 6 |->
    hostDataOut == regFlat[selState.regIndex*16 +: 16])
    else $error("data window read wrong");
  chk_byte_read: assert property (
    hostAck && hostRd && selState.byteMode |-> hostDataOut[15:8] == 8'h00)
    else $error("byte read not zero extended");
endmodule
bind irap_host_port irap_host_port_monitor #(.NUM_REGS(NUM_REGS)) mon_i (.*);

/* irap_host_model.sv */
// Host bus master model driving the port pins
`timescale 1ns/1ns
module irap_host_model (
  // Clock and answer
  input  wire logic        sys_clk,
  input  wire logic        hostAck,
  input  wire logic [15:0] hostDataOut,
  // Host pins
  output logic             hostSel,
  output logic             hostRd,
  output logic             hostWr,
  output logic             portSelect,
  output logic [15:0]      hostDataIn
);
  initial begin
    {hostSel, hostRd, hostWr, portSelect} = 4'h0;
    hostDataIn = 16'h5a5a;
  end
  // One access: pins held through the edge that samples the answer
  task automatic xfer(input logic wr, sel, input logic [15:0] d,
                      output logic [15:0] q, output bit ok);
    int n;
    @(negedge sys_clk);
    {hostSel, hostRd, hostWr, portSelect} = {1'b1, !wr, wr, sel};
    hostDataIn = d;
    for (n = 0; n < 20 && hostAck !== 1'b1; n++) @(negedge sys_clk);
    ok = n < 20;
    // Answer stands; take the data at the rising edge, release after
    @(posedge sys_clk);
    q = hostDataOut;
    @(negedge sys_clk);
    {hostSel, hostRd, hostWr} = 3'h0;
    // Released bus shows a flipped value, never the old data
    hostDataIn = ~d;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule

/* test_irap_host_port.sv */
// Self-checking bench for the indirect register access port
`timescale 1ns/1ns
module test_irap_host_port;
  import irap_pkg::*;
  logic sys_clk, nrst, hostSel, hostRd, hostWr, portSelect;
  logic hostDataOe_n, hostAck;
  logic [15:0] hostDataIn, hostDataOut, q;
  logic [95:0] regFlat;
  irap_sel_s selState;
  int bad_count = 0;
  int compares = 0;
  bit ok;
  // Rows: index, word written, word expected back
  logic [34:0] rows [6] = '{{3'h0, 16'h8001, 16'h8001},
    {3'h1, 16'h4002, 16'h4002}, {3'h2, 16'h2004, 16'h2004},
    {3'h3, 16'h1008, 16'h1008}, {3'h4, 16'hffff, 16'hffff},
    {3'h5, 16'h7e81, 16'h7e81}};
  irap_host_model host_i (.*);
  irap_host_port irap_host_port_i (.*);
  task automatic check(input logic [15:0] seen, want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input logic wr, sel, input logic [15:0] d);
    host_i.xfer(wr, sel, d, q, ok);
    if (!ok) begin
      bad_count++;
      close_out();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    nrst = 1'b0;
    repeat (12) @(negedge sys_clk);
    check(16'(selState), 16'h0000);
    check(hostDataOut, 16'h0000);
    check({15'h0000, hostDataOe_n}, 16'h0001);
    check({15'h0000, hostAck}, 16'h0000);
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1, 1, {12'h000, rows[i][34:32], 1'b0});
      acc(1, 0, rows[i][31:16]);
    end
    for (int i = 0; i < 6; i++) begin
      acc(1, 1, {12'h000, rows[i][34:32], 1'b0});
      acc(0, 1, 16'h0000);
      check(q, {12'h000, rows[i][34:32], 1'b0});
      acc(0, 0, 16'h0000);
      check(q, rows[i][15:0]);
      acc(0, 0, 16'h0000);
      check(q, rows[i][15:0]);
      check(regFlat[i*16 +: 16], rows[i][15:0]);
    end
    // Reserved bits dropped, then an undefined index refused
    acc(1, 1, 16'hff7a);
    acc(0, 1, 16'h0000);
    check(q, 16'h000a);
    acc(1, 1, 16'h000c);
    acc(1, 0, 16'hbeef);
    acc(0, 0, 16'h0000);
    check(q, 16'h0000);
    // Mid-run reset, then byte mode held for the rest of the run
    nrst = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    check(regFlat[63:48], 16'h0000);
    check(16'(selState), 16'h0000);
    acc(1, 1, 16'h0087);
    acc(1, 0, 16'h00cd);
    acc(0, 0, 16'h0000);
    check(q, 16'h00cd);
    check(regFlat[63:48], 16'hcd00);
    acc(1, 1, 16'h0086);
    acc(1, 0, 16'h0012);
    check(regFlat[63:48], 16'hcd12);
    close_out();
  end
endmodule
